/* File: rtl/ssind_pkg.sv */
// Package for the soft starter status indication block.
// Assumes one 200 MHz system clock shared by every user of these constants.
package ssind_pkg;

    // ------------------------------------------------------------------
    // State codes shown on the display terminal
    // ------------------------------------------------------------------
    typedef enum logic [4:0]
    {
        SSIND_ST_READY       = 5'h00,
        SSIND_ST_NO_MAINS    = 5'h01,
        SSIND_ST_CSL_WARN    = 5'h02,
        SSIND_ST_RUNNING     = 5'h03,
        SSIND_ST_BYPASS      = 5'h04,
        SSIND_ST_RAMP_UP     = 5'h05,
        SSIND_ST_RAMP_DOWN   = 5'h06,
        SSIND_ST_RESTART_W   = 5'h07,
        SSIND_ST_FAULT       = 5'h08,
        SSIND_ST_FREEWHEEL   = 5'h09,
        SSIND_ST_BRAKING     = 5'h0A,
        SSIND_ST_CASCADE_W   = 5'h0B,
        SSIND_ST_CUR_LIMIT   = 5'h0C,
        SSIND_ST_PREHEAT_DLY = 5'h0D,
        SSIND_ST_PREHEAT_INJ = 5'h0E,
        SSIND_ST_SMALL_TEST  = 5'h0F,
        SSIND_ST_FW_UPDATE   = 5'h10,
        SSIND_ST_DEMO        = 5'h11
    } ssind_state_t;

    // ------------------------------------------------------------------
    // Status LED colour codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SSIND_LED_OFF    = 2'h0,
        SSIND_LED_GREEN  = 2'h1,
        SSIND_LED_YELLOW = 2'h2
    } ssind_color_t;

    // ------------------------------------------------------------------
    // Timing and reset values
    // ------------------------------------------------------------------
    localparam int          SSIND_CLK_MHZ         = 200;
    localparam int          SSIND_FLASH_MS        = 500;  // Slow flash half period.
    localparam int          SSIND_BLINK_MS        = 125;  // Fast blink half period.
    localparam int          SSIND_ACT_MS          = 50;   // Serial activity stretch.
    localparam int          SSIND_FLASH_CYC       = SSIND_FLASH_MS * 1000 * SSIND_CLK_MHZ;
    localparam int          SSIND_BLINK_CYC       = SSIND_BLINK_MS * 1000 * SSIND_CLK_MHZ;
    localparam int          SSIND_ACT_CYC         = SSIND_ACT_MS * 1000 * SSIND_CLK_MHZ;
    localparam logic [1:0]  SSIND_CSL_RESP_WARN   = 2'h2;
    localparam logic [3:0]  SSIND_SEL_MOTOR_CUR   = 4'h0;
    localparam logic [3:0]  SSIND_SEL_RESET       = SSIND_SEL_MOTOR_CUR;
    localparam int          SSIND_SYNC_LEN        = 3;

endpackage : ssind_pkg

/* File: rtl/ssind_top.sv */
// Status indication logic: front-panel LEDs and display state selection.
// Assumes sequencing inputs are on ref_clk_in; the serial activity line is asynchronous.
//
// Function
// [R1] Status LED dark when the starter is not ready to start.
// [R2] Status LED flashes green when idle and ready to start.
// [R3] Status LED blinks green, faster pattern, during ramps and other transitions.
// [R4] Status LED steady green while running.
// [R5] Status LED steady yellow during an identify-unit request.
// [R6] Warning LED flashes red when any warning is present.
// [R7] Warning LED steady red when an error is present.
// [R8] Serial LED flashes yellow on Modbus activity, dark otherwise.
// [R9] Detected error gives the fault state; display shows fault code.
// [R10] Running shows a selectable monitored value; reset selection is motor current.
// [R11] No run command with mains present reports ready.
// [R12] No run command with mains absent reports no mains.
// [R13] Supply loss, not running, response code 2 raises the supply-loss warning.
// [R14] Bypass, ramp up and ramp down each report their own state.
// [R15] Restart wait reported while the start delay runs.
// [R16] Freewheel reported when the serial link forced a freewheel stop.
// [R17] Braking reported while braking is active.
// [R18] Cascade wait reported while awaiting a run or stop command.
// [R19] Current limit reported and the displayed value flashes meanwhile.
// [R20] Preheat reported in two steps: delay running, then current injected.
// [R21] Small motor test, firmware update and demo each have a state.
// [R22] Parameter writes stay enabled in the fault state.
// [R23] Fixed priority: fault, special modes, warnings, running sub-states, idle.
`timescale 1ns/1ps

module ssind_top
#(
    parameter int FLASH_CYC = ssind_pkg::SSIND_FLASH_CYC,
    parameter int BLINK_CYC = ssind_pkg::SSIND_BLINK_CYC,
    parameter int ACT_CYC   = ssind_pkg::SSIND_ACT_CYC
)
(
    // Clock and reset.
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    // Sequencing conditions.
    input  wire logic        error_in,
    input  wire logic        warning_in,
    input  wire logic        run_cmd_in,
    input  wire logic        mains_ok_in,
    input  wire logic        running_in,
    input  wire logic        ctrl_supply_lost_in,
    input  wire logic [1:0]  ctrl_supply_loss_response_in,
    input  wire logic        bypass_in,
    input  wire logic        ramp_up_in,
    input  wire logic        ramp_down_in,
    input  wire logic        restart_delay_in,
    input  wire logic        freewheel_in,
    input  wire logic        braking_in,
    input  wire logic        cascade_mode_in,
    input  wire logic        current_limit_in,
    input  wire logic        preheat_order_in,
    input  wire logic        pre_preheat_delay_done_in,
    input  wire logic        small_motor_test_in,
    input  wire logic        fw_update_in,
    input  wire logic        demo_in,
    input  wire logic        identify_in,
    // Display selection.
    input  wire logic        display_sel_we_in,
    input  wire logic [3:0]  display_sel_in,
    // Serial port activity, asynchronous.
    input  wire logic        serial_rx_act_in,
    // Display outputs.
    output logic [4:0]       state_code_out,
    output logic             show_value_out,
    output logic [3:0]       display_select_menu_out,
    output logic             value_flash_out,
    output logic             param_write_en_out,
    // LED outputs.
    output logic             status_green_out,
    output logic             status_yellow_out,
    output logic             warn_red_out,
    output logic             serial_activity_led_out
);

    // ------------------------------------------------------------------
    // Pattern timers
    // ------------------------------------------------------------------
    logic [31:0] flash_cnt_reg;
    logic [31:0] blink_cnt_reg;
    logic        flash_ph_reg;
    logic        blink_ph_reg;

    // Free-running slow flash phase; a shared phase keeps the ready flash, warning flash and value flash in step.
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            flash_cnt_reg <= 32'h0;
            flash_ph_reg  <= 1'b0;
        end
        else if (flash_cnt_reg >= 32'(FLASH_CYC - 1))
        begin
            flash_cnt_reg <= 32'h0;
            flash_ph_reg  <= ~flash_ph_reg;
        end
        else
        begin
            flash_cnt_reg <= flash_cnt_reg + 32'h1;
        end
    end

    // Faster blink phase, so transitions look different from ready.
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            blink_cnt_reg <= 32'h0;
            blink_ph_reg  <= 1'b0;
        end
        else if (blink_cnt_reg >= 32'(BLINK_CYC - 1))
        begin
            blink_cnt_reg <= 32'h0;
            blink_ph_reg  <= ~blink_ph_reg; // see [R3]
        end
        else
        begin
            blink_cnt_reg <= blink_cnt_reg + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // State selection
    // ------------------------------------------------------------------
    ssind_pkg::ssind_state_t state_next;
    logic                    csl_warn;

    assign csl_warn = ctrl_supply_lost_in && !running_in
                      && (ctrl_supply_loss_response_in == ssind_pkg::SSIND_CSL_RESP_WARN); // see [R13]

    // Priority chain; earlier branches mask later ones by design.
    always_comb
    begin
        if (error_in)
            state_next = ssind_pkg::SSIND_ST_FAULT;                 // see [R9] see [R23]
        else if (fw_update_in)
            state_next = ssind_pkg::SSIND_ST_FW_UPDATE;             // see [R21]
        else if (small_motor_test_in)
            state_next = ssind_pkg::SSIND_ST_SMALL_TEST;            // see [R21]
        else if (demo_in)
            state_next = ssind_pkg::SSIND_ST_DEMO;                  // see [R21]
        else if (csl_warn)
            state_next = ssind_pkg::SSIND_ST_CSL_WARN;              // see [R13]
        else if (freewheel_in)
            state_next = ssind_pkg::SSIND_ST_FREEWHEEL;             // see [R16]
        else if (braking_in)
            state_next = ssind_pkg::SSIND_ST_BRAKING;               // see [R17]
        else if (current_limit_in)
            state_next = ssind_pkg::SSIND_ST_CUR_LIMIT;             // see [R19]
        else if (ramp_up_in)
            state_next = ssind_pkg::SSIND_ST_RAMP_UP;               // see [R14]
        else if (ramp_down_in)
            state_next = ssind_pkg::SSIND_ST_RAMP_DOWN;             // see [R14]
        else if (bypass_in)
            state_next = ssind_pkg::SSIND_ST_BYPASS;                // see [R14]
        else if (running_in)
            state_next = ssind_pkg::SSIND_ST_RUNNING;
        else if (preheat_order_in && !pre_preheat_delay_done_in)
            state_next = ssind_pkg::SSIND_ST_PREHEAT_DLY;           // see [R20]
        else if (preheat_order_in)
            state_next = ssind_pkg::SSIND_ST_PREHEAT_INJ;           // see [R20]
        else if (restart_delay_in)
            state_next = ssind_pkg::SSIND_ST_RESTART_W;             // see [R15]
        else if (cascade_mode_in)
            state_next = ssind_pkg::SSIND_ST_CASCADE_W;             // see [R18]
        else if (!run_cmd_in && mains_ok_in)
            state_next = ssind_pkg::SSIND_ST_READY;                 // see [R11]
        else
            state_next = ssind_pkg::SSIND_ST_NO_MAINS;              // see [R12]
    end

    ssind_pkg::ssind_state_t state_reg;

    // Registered state is not read; the display code is registered separately from state_next.
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
            state_reg <= ssind_pkg::SSIND_ST_NO_MAINS;
        else
            state_reg <= state_next;
    end

    // ------------------------------------------------------------------
    // Display outputs
    // ------------------------------------------------------------------
    logic run_like;

    assign run_like = (state_next == ssind_pkg::SSIND_ST_RUNNING)
                      || (state_next == ssind_pkg::SSIND_ST_BYPASS)
                      || (state_next == ssind_pkg::SSIND_ST_CUR_LIMIT);

    // Monitored value shown while running; fault keeps parameters writable.
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_code_out     <= 5'h01;
            show_value_out     <= 1'b0;
            value_flash_out    <= 1'b0;
            param_write_en_out <= 1'b1;
        end
        else
        begin
            state_code_out     <= state_next;
            show_value_out     <= run_like;                                  // see [R10]
            value_flash_out    <= (state_next == ssind_pkg::SSIND_ST_CUR_LIMIT)
                                  && flash_ph_reg;                           // see [R19]
            param_write_en_out <= 1'b1;                                      // see [R22]
        end
    end

    // Selection of the monitored value; reset picks motor current.
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
            display_select_menu_out <= ssind_pkg::SSIND_SEL_RESET;           // see [R10]
        else if (display_sel_we_in)
            display_select_menu_out <= display_sel_in;
    end

    // ------------------------------------------------------------------
    // Status and warning LEDs
    // ------------------------------------------------------------------
    logic transitory;

    assign transitory = (state_next == ssind_pkg::SSIND_ST_RAMP_UP)
                        || (state_next == ssind_pkg::SSIND_ST_RAMP_DOWN)
                        || (state_next == ssind_pkg::SSIND_ST_BRAKING)
                        || (state_next == ssind_pkg::SSIND_ST_PREHEAT_DLY)
                        || (state_next == ssind_pkg::SSIND_ST_PREHEAT_INJ)
                        || (state_next == ssind_pkg::SSIND_ST_RESTART_W);

    // Identify overrides colour so the unit is found even while running.
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            status_green_out  <= 1'b0;
            status_yellow_out <= 1'b0;
        end
        else if (identify_in)
        begin
            status_green_out  <= 1'b0;
            status_yellow_out <= 1'b1;                                  // see [R5]
        end
        else
        begin
            status_yellow_out <= 1'b0;
            if (run_like)
                status_green_out <= 1'b1;                               // see [R4]
            else if (transitory)
                status_green_out <= blink_ph_reg;                       // see [R3]
            else if (state_next == ssind_pkg::SSIND_ST_READY)
                status_green_out <= flash_ph_reg;                       // see [R2]
            else
                status_green_out <= 1'b0;                               // see [R1]
        end
    end

    // Error beats warning on the shared red LED.
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
            warn_red_out <= 1'b0;
        else if (error_in)
            warn_red_out <= 1'b1;                                       // see [R7]
        else
            warn_red_out <= (warning_in || csl_warn) && flash_ph_reg;   // see [R6]
    end

    // ------------------------------------------------------------------
    // Serial activity LED
    // ------------------------------------------------------------------
    logic [ssind_pkg::SSIND_SYNC_LEN-1:0] act_sync_reg;
    logic [31:0]                          act_cnt_reg;

    // Three-stage synchroniser; only stages two and three are compared.
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
            act_sync_reg <= 3'h0;
        else
            act_sync_reg <= {act_sync_reg[1:0], serial_rx_act_in};
    end

    // Each settled edge restarts a stretch so short bursts stay visible.
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            act_cnt_reg             <= 32'h0;
            serial_activity_led_out <= 1'b0;
        end
        else
        begin
            if (act_sync_reg[1] != act_sync_reg[2])
                act_cnt_reg <= 32'(ACT_CYC);
            else if (act_cnt_reg != 32'h0)
                act_cnt_reg <= act_cnt_reg - 32'h1;
            serial_activity_led_out <= (act_cnt_reg != 32'h0) && blink_ph_reg; // see [R8]
        end
    end

endmodule : ssind_top

/* File: dv/ssind_term_mdl.sv */
// Model of the display terminal and serial traffic facing the status block.
// Assumes one shared clock; all drives change 1 ns after the rising edge.
`timescale 1ns/1ps

module ssind_term_mdl
(
    // Clock and commands from the bench.
    input  wire logic       ref_clk_in,
    input  wire logic       burst_in,
    input  wire logic       sel_req_in,
    input  wire logic [3:0] sel_val_in,
    // Lines toward the block.
    output logic            serial_rx_act_out,
    output logic            display_sel_we_out,
    output logic [3:0]      display_sel_out
);
    int edges_left = 0;

    // ------------------------------------------------------------------
    // Traffic and selection writes
    // ------------------------------------------------------------------
    // A burst is sixteen line changes two cycles apart; an even count leaves the line at its idle mark level.
    // When not writing, the selection lines invert on every cycle, so stale data never holds steady.
    initial
    begin
        serial_rx_act_out  = 1'b1;
        display_sel_we_out = 1'b0;
        display_sel_out    = 4'h0;
    end
    always @(posedge ref_clk_in)
    begin
        #1;
        if (burst_in && edges_left == 0)
            edges_left = 32;
        if (edges_left > 0)
            edges_left--;
        if (edges_left % 2 == 1)
            serial_rx_act_out = ~serial_rx_act_out;
        display_sel_we_out = sel_req_in;
        display_sel_out    = sel_req_in ? sel_val_in : ~display_sel_out;
    end
endmodule : ssind_term_mdl

/* File: dv/ssind_top_chk.sv */
// Checker for the status indication block, watching its ports only.
// Assumes it is bound into ssind_top and shares its clock and reset.
`timescale 1ns/1ps

module ssind_top_chk
#(
    parameter int BLINK_CYC = 2,
    parameter int ACT_CYC   = 20
)
(
    input wire logic       ref_clk_in, reset_in,
    input wire logic       error_in, fw_update_in, small_motor_test_in, demo_in,
    input wire logic       ctrl_supply_lost_in, running_in, identify_in,
    input wire logic [1:0] ctrl_supply_loss_response_in,
    input wire logic       display_sel_we_in, serial_rx_act_in,
    input wire logic [3:0] display_sel_in,
    input wire logic [4:0] state_code_out,
    input wire logic [3:0] display_select_menu_out,
    input wire logic       param_write_en_out, status_green_out, status_yellow_out,
    input wire logic       warn_red_out, serial_activity_led_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    // Helper counters; armed_reg masks the first edge after reset, where past values are reset values.
    logic        armed_reg;
    int unsigned flat_reg;
    int unsigned quiet_reg;
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            armed_reg <= 1'b0;
            flat_reg  <= 0;
            quiet_reg <= 0;
        end
        else
        begin
            armed_reg <= 1'b1;
            flat_reg  <= (state_code_out == ssind_pkg::SSIND_ST_RAMP_UP && !status_yellow_out &&
                          $stable(status_green_out)) ? flat_reg + 1 : 0;
            quiet_reg <= $changed(serial_rx_act_in) ? 0 : ((quiet_reg < 1000) ? quiet_reg + 1 : quiet_reg);
        end
    end

    sequence sel_write;
        display_sel_we_in;
    endsequence

    fault_code_a: assert property (error_in |=> state_code_out == ssind_pkg::SSIND_ST_FAULT)
        else $error("error input did not give the fault code");
    fault_red_a: assert property (error_in [*2] |=> warn_red_out && $past(warn_red_out))
        else $error("warning LED not steady on error");
    param_write_a: assert property (param_write_en_out)
        else $error("parameter writes disabled");
    sel_update_a: assert property (sel_write |=> display_select_menu_out == $past(display_sel_in))
        else $error("display selection not taken");
    csl_warn_a: assert property (!error_in && !fw_update_in && !small_motor_test_in && !demo_in &&
        ctrl_supply_lost_in && !running_in && ctrl_supply_loss_response_in == ssind_pkg::SSIND_CSL_RESP_WARN
        |=> state_code_out == ssind_pkg::SSIND_ST_CSL_WARN) else $error("supply loss warning state missing");
    identify_a: assert property (armed_reg && $past(identify_in) |-> status_yellow_out && !status_green_out)
        else $error("identify did not give steady yellow");
    run_green_a: assert property ((state_code_out == ssind_pkg::SSIND_ST_RUNNING && !status_yellow_out) [*3]
        |-> status_green_out && $stable(status_green_out)) else $error("status LED not steady green while running");
    dark_a: assert property (state_code_out == ssind_pkg::SSIND_ST_NO_MAINS && !status_yellow_out |-> !status_green_out)
        else $error("status LED lit without mains");
    blink_rate_a: assert property (flat_reg < BLINK_CYC + 2)
        else $error("status LED not blinking during ramp");
    serial_dark_a: assert property (quiet_reg > ACT_CYC + 8 |-> !serial_activity_led_out)
        else $error("serial LED lit without activity");
endmodule : ssind_top_chk

bind ssind_top ssind_top_chk #(.BLINK_CYC(BLINK_CYC), .ACT_CYC(ACT_CYC)) ssind_top_chk_i
(
    .ref_clk_in, .reset_in, .error_in, .fw_update_in, .small_motor_test_in, .demo_in, .ctrl_supply_lost_in,
    .running_in, .identify_in, .ctrl_supply_loss_response_in, .display_sel_we_in, .serial_rx_act_in,
    .display_sel_in, .state_code_out, .display_select_menu_out, .param_write_en_out, .status_green_out,
    .status_yellow_out, .warn_red_out, .serial_activity_led_out
);

/* File: dv/testbench.sv */
// Self-checking bench for the status indication block and its terminal model.
// Assumes short flash, blink and activity counts so the whole run stays brief.
`timescale 1ns/1ps

module testbench;
    localparam int FLASH_CYC = 8;
    localparam int BLINK_CYC = 2;
    localparam int ACT_CYC   = 20;

    logic        ref_clk_in = 1'b0;
    logic        reset_in   = 1'b1;
    logic [19:0] cond       = 20'h0;  // Conditions, highest display priority in the top bit.
    logic [1:0]  resp       = ssind_pkg::SSIND_CSL_RESP_WARN;
    logic        burst      = 1'b0;
    logic        sel_req    = 1'b0;
    logic [3:0]  sel_val    = 4'h5;
    logic        ser_act, sel_we, show, flash, pwe, green, yellow, red, sled;
    logic [3:0]  sel, menu;
    logic [4:0]  code;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          tg_g, tg_r, tg_v, ready_tg;
    ssind_pkg::ssind_state_t exp_tab [4:19];

    always #2.5 ref_clk_in = ~ref_clk_in;

    ssind_top #(.FLASH_CYC(FLASH_CYC), .BLINK_CYC(BLINK_CYC), .ACT_CYC(ACT_CYC)) ssind_top_i
    (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .error_in(cond[19]), .fw_update_in(cond[18]),
        .small_motor_test_in(cond[17]), .demo_in(cond[16]), .ctrl_supply_lost_in(cond[15]),
        .freewheel_in(cond[14]), .braking_in(cond[13]), .current_limit_in(cond[12]), .ramp_up_in(cond[11]),
        .ramp_down_in(cond[10]), .bypass_in(cond[9]), .running_in(cond[8]), .pre_preheat_delay_done_in(cond[7]),
        .preheat_order_in(cond[6]), .restart_delay_in(cond[5]), .cascade_mode_in(cond[4]), .run_cmd_in(cond[3]),
        .mains_ok_in(cond[2]), .warning_in(cond[1]), .identify_in(cond[0]), .ctrl_supply_loss_response_in(resp),
        .display_sel_we_in(sel_we), .display_sel_in(sel), .serial_rx_act_in(ser_act), .state_code_out(code),
        .show_value_out(show), .display_select_menu_out(menu), .value_flash_out(flash),
        .param_write_en_out(pwe), .status_green_out(green), .status_yellow_out(yellow), .warn_red_out(red),
        .serial_activity_led_out(sled)
    );

    ssind_term_mdl ssind_term_mdl_i
    (
        .ref_clk_in(ref_clk_in), .burst_in(burst), .sel_req_in(sel_req), .sel_val_in(sel_val),
        .serial_rx_act_out(ser_act), .display_sel_we_out(sel_we), .display_sel_out(sel)
    );

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (!ok)
        begin
            n_mismatch++;
            $display("BAD at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic settle();
        @(posedge ref_clk_in);
        #1;
    endtask : settle

    task automatic drive(input logic [19:0] c);
        settle();
        cond = c;
    endtask : drive

    // Counts LED and flash changes over n cycles, after the one-cycle latency has passed.
    task automatic watch(input int n);
        logic g, r, v;
        settle();
        tg_g = 0;
        tg_r = 0;
        tg_v = 0;
        for (int i = 0; i < n; i++)
        begin
            g = green;
            r = red;
            v = flash;
            settle();
            tg_g += int'(g !== green);
            tg_r += int'(r !== red);
            tg_v += int'(v !== flash);
        end
    endtask : watch

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        logic [19:0] c;
        exp_tab = '{ssind_pkg::SSIND_ST_CASCADE_W, ssind_pkg::SSIND_ST_RESTART_W, ssind_pkg::SSIND_ST_PREHEAT_DLY,
                    ssind_pkg::SSIND_ST_PREHEAT_INJ, ssind_pkg::SSIND_ST_RUNNING, ssind_pkg::SSIND_ST_BYPASS,
                    ssind_pkg::SSIND_ST_RAMP_DOWN, ssind_pkg::SSIND_ST_RAMP_UP, ssind_pkg::SSIND_ST_CUR_LIMIT,
                    ssind_pkg::SSIND_ST_BRAKING, ssind_pkg::SSIND_ST_FREEWHEEL, ssind_pkg::SSIND_ST_CSL_WARN,
                    ssind_pkg::SSIND_ST_DEMO, ssind_pkg::SSIND_ST_SMALL_TEST, ssind_pkg::SSIND_ST_FW_UPDATE,
                    ssind_pkg::SSIND_ST_FAULT};
        repeat (3) @(posedge ref_clk_in);
        #1 reset_in = 1'b0;
        settle();
        chk(menu === ssind_pkg::SSIND_SEL_RESET, "selection after reset");
        // Each condition from error down to cascade raised with every lower one down to cascade, plus mains; running is kept out above its own slot.
        for (int i = 19; i >= 4; i--)
        begin
            c = (20'h1 << i) | (((20'h1 << i) - 20'h1) & 20'hFFFF0) | 20'h4;
            if (i > 8)
                c[8] = 1'b0;
            drive(c);
            settle();
            chk(code === exp_tab[i], "priority state code");
            chk(pwe === 1'b1, "parameter writes");
        end
        drive(20'h4);
        watch(32);
        ready_tg = tg_g;
        chk(code === ssind_pkg::SSIND_ST_READY && tg_g > 0, "ready flash");
        drive(20'h804);
        watch(32);
        chk(tg_g > ready_tg, "ramp blink not faster than ready flash");
        drive(20'h0);
        watch(16);
        chk(code === ssind_pkg::SSIND_ST_NO_MAINS && green === 1'b0 && tg_g == 0, "dark without mains");
        resp = 2'h1;
        drive(20'h8004);
        settle();
        chk(code !== ssind_pkg::SSIND_ST_CSL_WARN, "supply loss warning with other response");
        resp = ssind_pkg::SSIND_CSL_RESP_WARN;
        drive(20'h810C);
        watch(16);
        chk(code === ssind_pkg::SSIND_ST_RUNNING && green === 1'b1 && tg_g == 0, "running steady");
        chk(show === 1'b1 && tg_v == 0, "running value shown, not flashing");
        sel_req = 1'b1;
        settle();
        sel_req = 1'b0;
        settle();
        settle();
        chk(menu === 4'h5, "selection write");
        drive(20'h10D);
        settle();
        chk(yellow === 1'b1 && green === 1'b0, "identify yellow");
        drive(20'h6);
        watch(32);
        chk(tg_r > 0, "warning flash");
        drive(20'h80004);
        watch(16);
        chk(red === 1'b1 && tg_r == 0, "error steady red");
        drive(20'h1004);
        watch(32);
        chk(tg_v > 0 && show === 1'b1, "current limit value flash");
        burst = 1'b1;
        settle();
        burst = 1'b0;
        for (int i = 0; sled !== 1'b1; i++)
        begin
            if (i == 60)
            begin
                chk(1'b0, "serial LED never lit");
                give_verdict();
            end
            settle();
        end
        repeat (ACT_CYC + 60) settle();
        chk(sled === 1'b0, "serial LED lit after traffic");
        give_verdict();
    end
endmodule : testbench
